// file: inc/pwm_pkg.sv
package pwm_pkg;
    // Byte addresses of the word registers
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_COUNT = 5'h04;
    localparam logic [4:0] ADDR_PERIOD = 5'h08;
    localparam logic [4:0] ADDR_SC0 = 5'h0c;
    localparam logic [4:0] ADDR_MATCH0 = 5'h10;
    localparam logic [4:0] ADDR_SC1 = 5'h14;
    localparam logic [4:0] ADDR_MATCH1 = 5'h18;
    // Bit positions in the control/status registers
    localparam int FLAG_BIT = 7;
    localparam int IE_BIT = 6;
    localparam int HALT_BIT = 5;
    localparam int CRST_BIT = 4;
    localparam int LINK_BIT = 5;
    localparam int MSA_BIT = 4;
    localparam int ACT_HI = 3;
    localparam int ACT_LO = 2;
    localparam int TOV_BIT = 1;
    localparam int MAX_BIT = 0;
    // Values after reset
    localparam logic [15:0] PERIOD_RST = 16'hffff;
    localparam logic [15:0] MATCH_RST = 16'h0000;
    localparam logic [6:0] CTL_RST = 7'h00;
    localparam logic [2:0] PS_RST = 3'h0;
    // Second channel has no link bit
    localparam logic [6:0] CTL1_MASK = 7'h5f;
    // Encodings
    localparam logic [1:0] MODE_UNBUF = 2'h1;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;
    localparam logic [2:0] PS_NONE = 3'h7;
    localparam int PRE_W = 6;
endpackage : pwm_pkg

// file: inc/cnt_if.sv
`timescale 1ns/1ps
// Counter timing shared by the compare units
interface cnt_if;
    logic tick;
    logic wrap;
    logic [15:0] next_cnt;
    modport src (output tick, output wrap, output next_cnt);
    modport dst (input tick, input wrap, input next_cnt);
endinterface : cnt_if

// file: rtl/pwm_compare_unit.sv
`timescale 1ns/1ps
module pwm_compare_unit (
    input wire logic clk_i,
    input wire logic rst_i,
    cnt_if.dst cnt,
    input wire logic enable_i,
    input wire logic [1:0] action_i,
    input wire logic tov_i,
    input wire logic full_i,
    input wire logic [15:0] match_i,
    output logic pin_o,
    output logic match_o
);
    logic pin_reg;
    logic pin_next;
    wire hit = enable_i && cnt.tick && (cnt.next_cnt == match_i);
    wire tog = enable_i && cnt.wrap && tov_i;
    // Compare level is the complement of the pulse level
    wire active_lvl = (action_i == pwm_pkg::ACT_CLEAR);

    // Toggle first, compare after: a zero match still wins at the wrap
    always_comb begin
        pin_next = pin_reg;
        if (tog) begin
            pin_next = ~pin_reg;
        end
        if (hit) begin
            unique case (action_i)
                pwm_pkg::ACT_TOGGLE: pin_next = ~pin_next;
                pwm_pkg::ACT_CLEAR: pin_next = 1'b0;
                pwm_pkg::ACT_SET: pin_next = 1'b1;
                default: pin_next = pin_next;
            endcase
        end
        if (enable_i && full_i && tov_i) begin
            pin_next = active_lvl;
        end
    end

    // Pin level register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_reg <= 1'b0;
        end else begin
            pin_reg <= pin_next;
        end
    end

    assign pin_o = pin_reg;
    assign match_o = hit;

    property p_full_duty;
        @(posedge clk_i) disable iff (rst_i)
        (enable_i && full_i && tov_i) [*2] |-> (pin_o == active_lvl);
    endproperty
    a_full_duty: assert property (p_full_duty) else $error("full duty not held");
endmodule : pwm_compare_unit

// file: rtl/pwm_timer.sv
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - Link bit set joins channels 0 and 1; output only on first pin.
// - Set 0 rules first; the last written set takes over at each wrap.
// - Linked: first control register governs; second pin released.
// - Overflow toggle flips the pin at each wrap, except with full duty or a zero match.
// - Pulse width runs from wrap to compare match.
// - Period is limit value plus one prescaled clocks.
// - Duty equals match value over period count.
// - Mode 01 unbuffered, 10 buffered; action 10 clear, 11 set.
// - Toggle disabled with clear on compare gives a constant low pin, zero duty.
// - Full duty plus toggle holds the pin active.
// - Wrap sets its flag; interrupt only while enabled.
// - Compare sets channel flag; interrupt only while enabled.
// - Counter runs in wait mode; registers closed; interrupts wake.
// - Counter reset bit clears counter and prescaler, reads zero.
// - Halt bit stops counting; set by system reset.
module pwm_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic wait_i,
    output logic first_channel_pin_o,
    output logic first_channel_pin_oe_n_o,
    output logic second_channel_pin_o,
    output logic second_channel_pin_oe_n_o,
    output logic wrap_irq_o,
    output logic ch0_irq_o,
    output logic ch1_irq_o,
    output logic wake_o
);
    // Low bits set for the selected divide ratio
    function automatic logic [pwm_pkg::PRE_W-1:0] pre_mask(input logic [2:0] ps);
        pre_mask = pwm_pkg::PRE_W'((7'h01 << ps) - 7'h01);
    endfunction : pre_mask

    // Byte-lane merge of a 16-bit value
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    logic ack_reg;
    logic [31:0] dat_reg;
    logic [31:0] rd_data;
    logic wrap_ie_reg;
    logic halt_reg;
    logic [2:0] ps_reg;
    logic [6:0] ctl0_reg;
    logic [6:0] ctl1_reg;
    logic [15:0] period_reg;
    logic [15:0] match0_reg;
    logic [15:0] match1_reg;
    logic [15:0] cnt_reg;
    logic [pwm_pkg::PRE_W-1:0] pre_reg;
    logic active_reg;
    logic active_next;
    logic last_reg;
    logic last_next;
    logic [2:0] flag_reg;
    logic [2:0] flag_next;
    logic [2:0] arm_reg;
    logic [2:0] arm_next;
    logic [2:0] clr;
    logic m0_hit;
    logic m1_hit;
    logic pin0;
    logic pin1;

    cnt_if cbus ();

    // Bus decode; registers are closed while the processor waits
    wire req = cyc_i && stb_i;
    wire [4:0] a = {adr_i[4:2], 2'h0};
    wire wr_go = req && we_i && ack_reg && !wait_i;
    wire rd_go = req && !we_i && ack_reg && !wait_i;
    wire hit_ctrl = (a == pwm_pkg::ADDR_CTRL);
    wire hit_sc0 = (a == pwm_pkg::ADDR_SC0);
    wire hit_sc1 = (a == pwm_pkg::ADDR_SC1);
    wire hit_period = (a == pwm_pkg::ADDR_PERIOD);
    wire hit_m0 = (a == pwm_pkg::ADDR_MATCH0);
    wire hit_m1 = (a == pwm_pkg::ADDR_MATCH1);
    wire wr_ctrl = wr_go && hit_ctrl && sel_i[0];
    wire wr_sc0 = wr_go && hit_sc0 && sel_i[0];
    wire wr_sc1 = wr_go && hit_sc1 && sel_i[0];
    wire wr_m0 = wr_go && hit_m0 && (|sel_i[1:0]);
    wire wr_m1 = wr_go && hit_m1 && (|sel_i[1:0]);

    // Channel mode decoding
    wire link = ctl0_reg[pwm_pkg::LINK_BIT];
    wire [1:0] mode0 = {link, ctl0_reg[pwm_pkg::MSA_BIT]};
    wire [1:0] act0 = ctl0_reg[pwm_pkg::ACT_HI:pwm_pkg::ACT_LO];
    wire [1:0] act1 = ctl1_reg[pwm_pkg::ACT_HI:pwm_pkg::ACT_LO];
    wire en0 = (mode0 == pwm_pkg::MODE_UNBUF) || mode0[1];
    wire en1 = !link && ctl1_reg[pwm_pkg::MSA_BIT];
    wire drive0 = en0 && (act0 != 2'h0);
    wire drive1 = en1 && (act1 != 2'h0);

    // Prescaler and counter timing
    wire crst = wr_ctrl && dat_i[pwm_pkg::CRST_BIT];
    wire [pwm_pkg::PRE_W-1:0] mask = pre_mask(ps_reg);
    wire tick = !halt_reg && (ps_reg != pwm_pkg::PS_NONE) && ((pre_reg & mask) == mask);
    wire wrap = tick && (cnt_reg == period_reg);
    wire [15:0] next_cnt = wrap ? 16'h0000 : cnt_reg + 16'h0001;

    assign cbus.tick = tick;
    assign cbus.wrap = wrap;
    assign cbus.next_cnt = next_cnt;

    // Prescaler and counter; the reset bit itself is never stored
    always_ff @(posedge clk_i) begin
        if (rst_i || crst) begin
            cnt_reg <= 16'h0000;
            pre_reg <= '0;
        end else if (!halt_reg) begin
            pre_reg <= pre_reg + 1'b1;
            if (tick) begin
                cnt_reg <= next_cnt;
            end
        end
    end

    // Main control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wrap_ie_reg <= 1'b0;
            halt_reg <= 1'b1;
            ps_reg <= pwm_pkg::PS_RST;
        end else if (wr_ctrl) begin
            wrap_ie_reg <= dat_i[pwm_pkg::IE_BIT];
            halt_reg <= dat_i[pwm_pkg::HALT_BIT];
            ps_reg <= dat_i[2:0];
        end
    end

    // Channel control registers; second one loses its link bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl0_reg <= pwm_pkg::CTL_RST;
            ctl1_reg <= pwm_pkg::CTL_RST;
        end else begin
            if (wr_sc0) begin
                ctl0_reg <= dat_i[6:0];
            end
            if (wr_sc1) begin
                ctl1_reg <= dat_i[6:0] & pwm_pkg::CTL1_MASK;
            end
        end
    end

    // Period limit and match values
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            period_reg <= pwm_pkg::PERIOD_RST;
            match0_reg <= pwm_pkg::MATCH_RST;
            match1_reg <= pwm_pkg::MATCH_RST;
        end else begin
            if (wr_go && hit_period) begin
                period_reg <= merge16(period_reg, dat_i, sel_i);
            end
            if (wr_m0) begin
                match0_reg <= merge16(match0_reg, dat_i, sel_i);
            end
            if (wr_m1) begin
                match1_reg <= merge16(match1_reg, dat_i, sel_i);
            end
        end
    end

    // Buffered set selection; the swap is taken on the wrap edge itself
    // so the compare at that edge already sees the new width
    always_comb begin
        last_next = last_reg;
        if (!link) begin
            last_next = 1'b0;
        end else if (wr_m1) begin
            last_next = 1'b1;
        end else if (wr_m0) begin
            last_next = 1'b0;
        end
        active_next = active_reg;
        if (!link) begin
            active_next = 1'b0;
        end else if (wrap) begin
            active_next = last_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            active_reg <= active_next;
            last_reg <= last_next;
        end
    end

    wire [15:0] match0_use = active_next ? match1_reg : match0_reg;

    // First channel carries the linked output
    pwm_compare_unit u_ch0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cnt(cbus.dst),
        .enable_i(en0),
        .action_i(act0),
        .tov_i(ctl0_reg[pwm_pkg::TOV_BIT]),
        .full_i(ctl0_reg[pwm_pkg::MAX_BIT]),
        .match_i(match0_use),
        .pin_o(pin0),
        .match_o(m0_hit)
    );

    pwm_compare_unit u_ch1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cnt(cbus.dst),
        .enable_i(en1),
        .action_i(act1),
        .tov_i(ctl1_reg[pwm_pkg::TOV_BIT]),
        .full_i(ctl1_reg[pwm_pkg::MAX_BIT]),
        .match_i(match1_reg),
        .pin_o(pin1),
        .match_o(m1_hit)
    );

    // Flags: read while set arms, write 0 then clears; a new event
    // disarms so a clear racing an event can never lose it
    wire [2:0] ev = {m1_hit, m0_hit, wrap};
    wire [2:0] hitv = {hit_sc1, hit_sc0, hit_ctrl};
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            clr[i] = wr_go && hitv[i] && sel_i[0] && !dat_i[pwm_pkg::FLAG_BIT] && arm_reg[i];
            flag_next[i] = ev[i] || (flag_reg[i] && !clr[i]);
            arm_next[i] = arm_reg[i];
            if (ev[i]) begin
                arm_next[i] = 1'b0;
            end else if (rd_go && hitv[i] && flag_reg[i]) begin
                arm_next[i] = 1'b1;
            end else if (wr_go && hitv[i]) begin
                arm_next[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_reg <= 3'h0;
            arm_reg <= 3'h0;
        end else begin
            flag_reg <= flag_next;
            arm_reg <= arm_next;
        end
    end

    // Read data mux; closed registers read as zero
    always_comb begin
        rd_data = 32'h0000_0000;
        if (!wait_i) begin
            case (a)
                pwm_pkg::ADDR_CTRL:
                    rd_data = {24'h0, flag_reg[0], wrap_ie_reg, halt_reg, 2'h0, ps_reg};
                pwm_pkg::ADDR_COUNT: rd_data = {16'h0, cnt_reg};
                pwm_pkg::ADDR_PERIOD: rd_data = {16'h0, period_reg};
                pwm_pkg::ADDR_SC0: rd_data = {24'h0, flag_reg[1], ctl0_reg};
                pwm_pkg::ADDR_MATCH0: rd_data = {16'h0, match0_reg};
                pwm_pkg::ADDR_SC1: rd_data = {24'h0, flag_reg[2], ctl1_reg};
                pwm_pkg::ADDR_MATCH1: rd_data = {16'h0, match1_reg};
                default: rd_data = 32'h0000_0000;
            endcase
        end
    end

    // One wait state: data is latched together with the acknowledge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= req && !ack_reg;
            dat_reg <= rd_data;
        end
    end

    assign ack_o = ack_reg && req;
    assign dat_o = dat_reg;

    // Pins and interrupt requests
    assign first_channel_pin_o = pin0;
    assign first_channel_pin_oe_n_o = !drive0;
    assign second_channel_pin_o = pin1;
    assign second_channel_pin_oe_n_o = !drive1;
    assign wrap_irq_o = flag_reg[0] && wrap_ie_reg;
    assign ch0_irq_o = flag_reg[1] && ctl0_reg[pwm_pkg::IE_BIT];
    assign ch1_irq_o = flag_reg[2] && ctl1_reg[pwm_pkg::IE_BIT];
    assign wake_o = wait_i && (wrap_irq_o || ch0_irq_o || ch1_irq_o);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_link_wrap;
        link && wrap;
    endsequence

    sequence s_crst;
        crst ##1 1'b1;
    endsequence

    property p_linked_pins;
        link |-> second_channel_pin_oe_n_o;
    endproperty
    a_linked_pins: assert property (p_linked_pins) else $error("second pin held");

    property p_swap;
        s_link_wrap |=> (active_reg == $past(last_reg));
    endproperty
    a_swap: assert property (p_swap) else $error("set not swapped at wrap");

    property p_hold_set;
        (link && !wrap) |=> $stable(active_reg);
    endproperty
    a_hold_set: assert property (p_hold_set) else $error("set changed mid period");

    property p_wrap_zero;
        wrap && !crst |=> (cnt_reg == 16'h0000) && flag_reg[0];
    endproperty
    a_wrap_zero: assert property (p_wrap_zero) else $error("wrap not taken");

    property p_crst;
        s_crst |-> (cnt_reg == 16'h0000) && (pre_reg == '0);
    endproperty
    a_crst: assert property (p_crst) else $error("counter reset failed");

    property p_halt;
        (halt_reg && !crst) |=> $stable(cnt_reg) && $stable(pre_reg);
    endproperty
    a_halt: assert property (p_halt) else $error("counter moved while halted");

    property p_ch_flag;
        m0_hit |=> flag_reg[1] ##0 (ch0_irq_o == ctl0_reg[pwm_pkg::IE_BIT]);
    endproperty
    a_ch_flag: assert property (p_ch_flag) else $error("channel flag missing");

    property p_toggle;
        (wrap && en0 && ctl0_reg[pwm_pkg::TOV_BIT] && !ctl0_reg[pwm_pkg::MAX_BIT]
            && (match0_use != 16'h0000)) |=> (pin0 != $past(pin0));
    endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle at wrap");

    property p_clear_at_match;
        (m0_hit && act0 == pwm_pkg::ACT_CLEAR && !ctl0_reg[pwm_pkg::MAX_BIT]) |=> !pin0;
    endproperty
    a_clear_at_match: assert property (p_clear_at_match) else $error("pulse not ended");

    property p_zero_duty;
        (en0 && !ctl0_reg[pwm_pkg::TOV_BIT] && act0 == pwm_pkg::ACT_CLEAR && !pin0)
            |=> !pin0;
    endproperty
    a_zero_duty: assert property (p_zero_duty) else $error("zero duty broken");
endmodule : pwm_timer

// file: testbench/pwm_load_model.sv
`timescale 1ns/1ps
// External load on the channel pin; measures pulse and period in clocks
module pwm_load_model (
    input wire logic clk_i,
    input wire logic pin_i,
    input wire logic oe_n_i,
    output logic lvl_o,
    output logic [15:0] high_len_o,
    output logic [15:0] per_len_o
);
    logic prev_reg = 1'b0;
    logic [15:0] run_reg = 16'h0000;
    logic [15:0] high_reg = 16'h0000;
    logic [15:0] per_reg = 16'h0000;
    // Pull-down: a released pin reads low, never the last driven value
    assign lvl_o = oe_n_i ? 1'b0 : pin_i;
    // One driver per measured length
    assign high_len_o = high_reg;
    assign per_len_o = per_reg;
    // Restart the run count at each rising edge of the load level
    always @(posedge clk_i) begin
        prev_reg <= lvl_o;
        if (lvl_o && !prev_reg) begin
            per_reg <= run_reg;
            run_reg <= 16'h0001;
        end else begin
            run_reg <= run_reg + 16'h0001;
            if (!lvl_o && prev_reg) begin
                high_reg <= run_reg;
            end
        end
    end
endmodule : pwm_load_model

// file: testbench/tb_buffered_compare_pwm_channel_pair.sv
`timescale 1ns/1ps
module tb_buffered_compare_pwm_channel_pair;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [4:0] adr_i = 5'h00;
    logic [3:0] sel_i = 4'h3;
    logic [31:0] dat_i = 32'h00000000;
    logic wait_i = 1'b0;
    logic [31:0] dat_o;
    logic ack_o, pin0, oe0_n, pin1, oe1_n, wrap_irq_o, ch0_irq_o, ch1_irq_o, wake_o;
    logic lvl;
    logic [15:0] high_len, per_len;
    int mismatches = 0;
    int compares = 0;

    pwm_timer u_pwm_timer (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .wait_i(wait_i), .first_channel_pin_o(pin0),
        .first_channel_pin_oe_n_o(oe0_n), .second_channel_pin_o(pin1),
        .second_channel_pin_oe_n_o(oe1_n), .wrap_irq_o(wrap_irq_o),
        .ch0_irq_o(ch0_irq_o), .ch1_irq_o(ch1_irq_o), .wake_o(wake_o));

    pwm_load_model u_pwm_load_model (.clk_i(clk_i), .pin_i(pin0), .oe_n_i(oe0_n),
        .lvl_o(lvl), .high_len_o(high_len), .per_len_o(per_len));

    // 50 MHz bus clock
    initial begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One classic cycle; request held until ack is sampled high
    task automatic wb(input logic [4:0] a, input logic w, input logic [15:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {16'h0000, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1) begin
            n++;
            if (n > 20) begin
                mismatches++;
                report_and_stop();
            end
            @(posedge clk_i);
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask : wr

    task automatic rdc(input logic [4:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        wb(a, 1'b0, 16'h0000, q);
        chk(nm, e, q);
    endtask : rdc

    // Halt and clear first, then program, then restart
    task automatic pwm_init(input logic [15:0] m, input logic [15:0] sc);
        wr(pwm_pkg::ADDR_CTRL, 16'h0030);
        wr(pwm_pkg::ADDR_PERIOD, 16'h00ff);
        wr(pwm_pkg::ADDR_MATCH0, m);
        wr(pwm_pkg::ADDR_SC0, sc);
        wr(pwm_pkg::ADDR_CTRL, 16'h0000);
    endtask : pwm_init

    // Bounded wait for a load level; running out counts as a mismatch
    task automatic wait_lvl(input logic v);
        int n;
        n = 0;
        while (lvl !== v) begin
            n++;
            if (n > 600) begin
                mismatches++;
                report_and_stop();
            end
            @(posedge clk_i);
        end
    endtask : wait_lvl

    task automatic cnt_high(input int n, input logic [31:0] e, input string nm);
        logic [31:0] k;
        k = 32'h0;
        repeat (n) begin
            @(posedge clk_i);
            k = k + {31'h0, lvl};
        end
        chk(nm, e, k);
    endtask : cnt_high

    task automatic t_reset();
        rdc(pwm_pkg::ADDR_CTRL, 32'h00000020, "ctrl reset");
        rdc(pwm_pkg::ADDR_PERIOD, 32'h0000ffff, "period reset");
        rdc(pwm_pkg::ADDR_COUNT, 32'h0, "count reset");
        rdc(pwm_pkg::ADDR_SC0, 32'h0, "sc0 reset");
        rdc(pwm_pkg::ADDR_SC1, 32'h0, "sc1 reset");
        chk("oe0_n reset", 32'h1, {31'h0, oe0_n});
        $display("test reset done");
    endtask : t_reset

    // Clear-on-compare with wrap toggle; flags, irqs and wait mode
    task automatic t_pwm();
        logic [31:0] q;
        pwm_init(16'h0080, 16'h001a);
        repeat (800) @(posedge clk_i);
        chk("period", 32'd256, {16'h0, per_len});
        chk("width", 32'd128, {16'h0, high_len});
        wb(pwm_pkg::ADDR_CTRL, 1'b0, 16'h0000, q);
        chk("wrap flag", 32'h1, {31'h0, q[7]});
        chk("wrap irq off", 32'h0, {31'h0, wrap_irq_o});
        // Flag bit written as 1 so the armed flag is left standing
        wr(pwm_pkg::ADDR_CTRL, 16'h00c0);
        chk("wrap irq on", 32'h1, {31'h0, wrap_irq_o});
        chk("ch0 irq off", 32'h0, {31'h0, ch0_irq_o});
        wr(pwm_pkg::ADDR_SC0, 16'h005a);
        chk("ch0 irq on", 32'h1, {31'h0, ch0_irq_o});
        wait_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("wake", 32'h1, {31'h0, wake_o});
        wr(pwm_pkg::ADDR_PERIOD, 16'h0011);
        rdc(pwm_pkg::ADDR_PERIOD, 32'h0, "read in wait");
        repeat (600) @(posedge clk_i);
        chk("period in wait", 32'd256, {16'h0, per_len});
        wait_i <= 1'b0;
        @(posedge clk_i);
        rdc(pwm_pkg::ADDR_PERIOD, 32'h000000ff, "write in wait dropped");
        wr(pwm_pkg::ADDR_CTRL, 16'h0060);
        wb(pwm_pkg::ADDR_CTRL, 1'b0, 16'h0000, q);
        wr(pwm_pkg::ADDR_CTRL, 16'h0060);
        chk("wrap irq cleared", 32'h0, {31'h0, wrap_irq_o});
        rdc(5'h1c, 32'h0, "unmapped");
        $display("test pwm done");
    endtask : t_pwm

    // Set-on-compare, zero duty and full duty
    task automatic t_limits();
        pwm_init(16'h0040, 16'h001e);
        repeat (800) @(posedge clk_i);
        chk("low pulse", 32'd192, {16'h0, high_len});
        pwm_init(16'h0080, 16'h0018);
        repeat (300) @(posedge clk_i);
        cnt_high(300, 32'd0, "zero duty");
        pwm_init(16'h0080, 16'h001b);
        repeat (300) @(posedge clk_i);
        cnt_high(300, 32'd300, "full duty");
        $display("test limits done");
    endtask : t_limits

    // Linked pair: writes go only to the inactive set
    task automatic t_linked();
        pwm_init(16'h0040, 16'h002a);
        repeat (600) @(posedge clk_i);
        chk("set0 width", 32'd64, {16'h0, high_len});
        chk("pin1 released", 32'h1, {31'h0, oe1_n});
        chk("pin0 driven", 32'h0, {31'h0, oe0_n});
        wr(pwm_pkg::ADDR_MATCH1, 16'h00c0);
        repeat (600) @(posedge clk_i);
        chk("set1 width", 32'd192, {16'h0, high_len});
        chk("linked period", 32'd256, {16'h0, per_len});
        wr(pwm_pkg::ADDR_MATCH0, 16'h0020);
        repeat (600) @(posedge clk_i);
        chk("set0 again", 32'd32, {16'h0, high_len});
        $display("test linked done");
    endtask : t_linked

    // Width changes timed from compare and wrap events; channel 1 on its own
    task automatic t_update();
        logic [31:0] q;
        logic [31:0] k;
        pwm_init(16'h0080, 16'h001a);
        wr(pwm_pkg::ADDR_MATCH1, 16'h0040);
        wr(pwm_pkg::ADDR_SC1, 16'h007a);
        repeat (600) @(posedge clk_i);
        chk("pin1 driven", 32'h0, {31'h0, oe1_n});
        chk("ch1 irq", 32'h1, {31'h0, ch1_irq_o});
        wb(pwm_pkg::ADDR_SC1, 1'b0, 16'h0000, q);
        chk("sc1 link bit", 32'h5a, q & 32'h7f);
        k = 32'h0;
        repeat (256) begin
            @(posedge clk_i);
            k = k + {31'h0, pin1};
        end
        chk("pin1 width", 32'd64, k);
        wait_lvl(1'b1);
        wait_lvl(1'b0);
        wr(pwm_pkg::ADDR_MATCH0, 16'h0040);
        repeat (600) @(posedge clk_i);
        chk("shorter width", 32'd64, {16'h0, high_len});
        wait_lvl(1'b0);
        wait_lvl(1'b1);
        wr(pwm_pkg::ADDR_MATCH0, 16'h00a0);
        repeat (600) @(posedge clk_i);
        chk("longer width", 32'd160, {16'h0, high_len});
        $display("test update done");
    endtask : t_update

    task automatic t_halt();
        logic [31:0] q;
        wr(pwm_pkg::ADDR_CTRL, 16'h0030);
        rdc(pwm_pkg::ADDR_COUNT, 32'h0, "count cleared");
        wb(pwm_pkg::ADDR_CTRL, 1'b0, 16'h0000, q);
        chk("reset bit reads 0", 32'h20, q & 32'h3f);
        repeat (20) @(posedge clk_i);
        rdc(pwm_pkg::ADDR_COUNT, 32'h0, "count halted");
        $display("test halt done");
    endtask : t_halt

    // Main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_pwm();
        t_limits();
        t_linked();
        t_update();
        t_halt();
        report_and_stop();
    end
endmodule : tb_buffered_compare_pwm_channel_pair
